//--- logic/scc_charge_ctrl.v
`include "scc_defs.vh"

// charge control of the switched capacitor charger
module scc_charge_ctrl #(
  parameter HP_W    = 16,
  parameter DT_W    = 8,
  parameter DEB_CYC = `SCC_ALM_DEB_CYC
) (
  // clock and reset (power-on reset)
  input  wire                   sys_clk,
  input  wire                   rst_b,
  // supply lockout and presence detectors
  input  wire                   uvlo_ok,
  input  wire                   input_one_present,
  input  wire                   input_two_present,
  input  wire                   bus_present,
  input  wire                   output_present,
  // bus voltage window comparators
  input  wire                   bus_window_low,
  input  wire                   bus_window_high,
  // protection comparators
  input  wire                   input_one_overvoltage,
  input  wire                   input_two_overvoltage,
  input  wire                   bus_overvoltage,
  input  wire                   bus_overcurrent,
  input  wire                   bus_undercurrent,
  input  wire                   output_overvoltage,
  input  wire                   bus_short_fault,
  input  wire                   battery_overvoltage,
  input  wire                   battery_overcurrent,
  input  wire                   connector_temp_fault,
  input  wire                   battery_temp_fault,
  input  wire                   die_overtemp_fault,
  input  wire [`SCC_FLT_W-1:0]  fault_enable,
  input  wire                   battery_ovp_alarm,
  // host writes (one-cycle strobes with data)
  input  wire                   charge_enable_bit_wr,
  input  wire                   charge_enable_bit_wdata,
  input  wire                   bypass_wr,
  input  wire                   bypass_wdata,
  input  wire                   hiz_wr,
  input  wire                   hiz_wdata,
  input  wire                   adc_en_wr,
  input  wire                   adc_en_wdata,
  input  wire [HP_W-1:0]        half_period,
  input  wire [DT_W-1:0]        dead_time,
  // host readback
  output reg                    charge_enable_bit,
  output reg                    bypass_select_bit,
  output reg                    high_impedance_request,
  output reg                    converter_active_flag,
  output reg                    adc_enable,
  output reg  [`SCC_FLT_W-1:0]  fault_latch,
  output reg                    alarm_flag,
  output reg                    interrupt_out_n,
  output reg                    serial_ready,
  // power path
  output reg                    internal_regulator,
  output reg                    sensing_on,
  output reg  [1:0]             input_fet_gate_drive,
  // switch gates, channel a and channel b
  output wire [3:0]             gates_a,
  output wire [3:0]             gates_b
);

  wire [`SCC_FLT_W-1:0] flt_raw;    // raw fault vector
  wire [`SCC_FLT_W-1:0] flt_act;    // enabled faults
  wire                  any_fault;  // any enabled fault active
  wire                  presence;   // bus and output present
  wire                  in_window;  // bus inside error window
  wire                  hiz_rise;   // 0 to 1 write of hiz
  wire                  run_div;    // divider switching allowed
  wire                  run_byp;    // bypass path on
  reg                   hiz_mode_reg;  // hiz state
  reg  [31:0]           deb_cnt_reg;   // alarm spacing count
  reg                   alm_d_reg;     // alarm input delayed
  reg                   flt_d_reg;     // fault delayed

  // fault vector in fixed bit order
  assign flt_raw = {die_overtemp_fault, battery_temp_fault,
                    connector_temp_fault, battery_overcurrent,
                    battery_overvoltage, bus_short_fault,
                    output_overvoltage, bus_undercurrent,
                    bus_overcurrent, bus_overvoltage,
                    input_two_overvoltage, input_one_overvoltage};
  assign flt_act   = flt_raw & fault_enable;
  assign any_fault = |flt_act;

  assign presence  = bus_present & output_present;
  // window check, above low and below high limit
  assign in_window = bus_window_low & ~bus_window_high;
  assign hiz_rise  = hiz_wr & hiz_wdata & ~high_impedance_request;

  assign run_div = converter_active_flag & ~bypass_select_bit & ~any_fault;
  assign run_byp = converter_active_flag & bypass_select_bit &
                   ~any_fault & presence;

  // host control bits
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      charge_enable_bit      <= `SCC_RST_CHARGE_ENABLE_BIT;
      bypass_select_bit      <= `SCC_RST_BYPASS;
      high_impedance_request <= `SCC_RST_HIZ;
      adc_enable             <= 1'b0;
    end else if (!uvlo_ok) begin
      // below lockout registers held at default
      charge_enable_bit      <= `SCC_RST_CHARGE_ENABLE_BIT;
      bypass_select_bit      <= `SCC_RST_BYPASS;
      high_impedance_request <= `SCC_RST_HIZ;
      adc_enable             <= 1'b0;
    end else begin
      // only the host clears the request
      if (hiz_wr) begin
        high_impedance_request <= hiz_wdata;
      end
      if (bypass_wr && !converter_active_flag) begin
        bypass_select_bit <= bypass_wdata;
      end
      // adc halted while hiz
      if (hiz_rise || hiz_mode_reg) begin
        adc_enable <= 1'b0;
      end else if (adc_en_wr) begin
        adc_enable <= adc_en_wdata;
      end
      // fault clears enable, wins over write
      if (any_fault || hiz_rise || hiz_mode_reg) begin
        charge_enable_bit <= 1'b0;
      end else if (charge_enable_bit_wr) begin
        charge_enable_bit <= charge_enable_bit_wdata & presence;
      end
    end
  end

  // hiz state, entered on rising request
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hiz_mode_reg <= 1'b0;
    end else if (!uvlo_ok) begin
      hiz_mode_reg <= 1'b0;
    end else if (hiz_rise) begin
      // entered on 0 to 1 write
      hiz_mode_reg <= 1'b1;
    end else if (hiz_wr && !hiz_wdata) begin
      hiz_mode_reg <= 1'b0;
    end
  end

  // converter state
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      converter_active_flag <= 1'b0;
    end else begin
      // enable starts converter and sets flag
      converter_active_flag <= charge_enable_bit & presence & in_window &
                               ~any_fault & ~hiz_mode_reg & uvlo_ok;
    end
  end

  // regulator, sensing and fault latch
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      internal_regulator <= 1'b0;
      sensing_on         <= 1'b0;
      serial_ready       <= 1'b0;
      fault_latch        <= {`SCC_FLT_W{1'b0}};
    end else begin
      serial_ready       <= uvlo_ok;
      internal_regulator <= uvlo_ok & presence & ~hiz_mode_reg;
      sensing_on         <= uvlo_ok & presence & ~hiz_mode_reg;
      // set wins over clear on a host clear strobe
      fault_latch <= (charge_enable_bit_wr && charge_enable_bit_wdata) ?
                     flt_act : (fault_latch | flt_act);
    end
  end

  // input fet gate drive per input
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      input_fet_gate_drive <= 2'b00;
    end else begin
      // overvoltage or short drops its fet
      // input one wins if both are valid together
      input_fet_gate_drive[0] <= uvlo_ok & ~hiz_mode_reg &
        input_one_present & ~flt_act[`SCC_FLT_INPUT_ONE_OVERVOLTAGE] &
        ~flt_act[`SCC_FLT_BUS_SCP];
      input_fet_gate_drive[1] <= uvlo_ok & ~hiz_mode_reg &
        input_two_present & ~input_one_present &
        ~flt_act[`SCC_FLT_INPUT_TWO_OVERVOLTAGE] & ~flt_act[`SCC_FLT_BUS_SCP];
    end
  end

  // alarm notification with debounce spacing
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      deb_cnt_reg     <= 32'h0000_0000;
      alm_d_reg       <= 1'b0;
      flt_d_reg       <= 1'b0;
      alarm_flag      <= 1'b0;
      interrupt_out_n <= 1'b1;
    end else begin
      alm_d_reg <= battery_ovp_alarm;
      flt_d_reg <= any_fault;
      alarm_flag      <= 1'b0;
      interrupt_out_n <= 1'b1;
      if (deb_cnt_reg != 32'h0000_0000) begin
        deb_cnt_reg <= deb_cnt_reg - 32'h0000_0001;
      // new alarm or fault edge, spaced
      end else if ((battery_ovp_alarm && !alm_d_reg) ||
                   (any_fault && !flt_d_reg)) begin
        alarm_flag      <= 1'b1;
        interrupt_out_n <= 1'b0;
        deb_cnt_reg     <= DEB_CYC - 1;
      end
    end
  end

  // two channels, b starts in opposite half
  scc_phase_gen #(.HP_W(HP_W), .DT_W(DT_W)) u_ch_a (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .run         (run_div),
    .bypass      (run_byp),
    .half_period (half_period),
    .dead_time   (dead_time),
    .start_phase (1'b0),
    .gate_reg    (gates_a)
  );

  scc_phase_gen #(.HP_W(HP_W), .DT_W(DT_W)) u_ch_b (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .run         (run_div),
    .bypass      (run_byp),
    .half_period (half_period),
    .dead_time   (dead_time),
    .start_phase (1'b1),
    .gate_reg    (gates_b)
  );

endmodule // scc_charge_ctrl

//--- pkg/scc_defs.vh
`ifndef SCC_DEFS_VH
`define SCC_DEFS_VH

// clock rate in kHz
`define SCC_CLK_KHZ        25000
// alarm debounce time in ms
`define SCC_ALM_DEB_MS     120
// debounce in cycles
`define SCC_ALM_DEB_CYC    (`SCC_ALM_DEB_MS * `SCC_CLK_KHZ)
// default half period of switching, cycles
`define SCC_HALF_PER_DEF   16'h0020
// default dead time, cycles
`define SCC_DEAD_DEF       8'h02
// reset values of host bits
`define SCC_RST_CHARGE_ENABLE_BIT     1'b0
`define SCC_RST_BYPASS     1'b0
`define SCC_RST_HIZ        1'b0
// fault vector positions
`define SCC_FLT_W          12
`define SCC_FLT_INPUT_ONE_OVERVOLTAGE   0
`define SCC_FLT_INPUT_TWO_OVERVOLTAGE   1
`define SCC_FLT_BUS_SCP    6
// switch index within a channel's gate vector
`define SCC_SW1            0
`define SCC_SW2            1
`define SCC_SW3            2
`define SCC_SW4            3

`endif

//--- logic/scc_phase_gen.v
`include "scc_defs.vh"

// one switching channel: 50% duty with dead time
module scc_phase_gen #(
  parameter HP_W = 16,
  parameter DT_W = 8
) (
  // clock and reset
  input  wire            sys_clk,
  input  wire            rst_b,
  // control
  input  wire            run,
  input  wire            bypass,
  input  wire [HP_W-1:0] half_period,
  input  wire [DT_W-1:0] dead_time,
  input  wire            start_phase,
  // gates, bit n drives switch n+1
  output reg  [3:0]      gate_reg
);

  reg  [HP_W-1:0] cnt_reg;   // position in half period
  reg             ph_reg;    // 0 = phase one, 1 = phase two
  reg  [3:0]      gate_next; // next gate pattern
  wire            last;      // end of half period

  assign last = (cnt_reg >= half_period - {{(HP_W-1){1'b0}}, 1'b1});

  // half period counter, phase toggles each half
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= {HP_W{1'b0}};
      ph_reg  <= 1'b0;
    end else if (!run) begin
      // restart so the two channels stay aligned
      cnt_reg <= {HP_W{1'b0}};
      ph_reg  <= start_phase;
    end else if (last) begin
      cnt_reg <= {HP_W{1'b0}};
      ph_reg  <= ~ph_reg;
    end else begin
      cnt_reg <= cnt_reg + {{(HP_W-1){1'b0}}, 1'b1};
    end
  end

  // gate pattern from phase and dead time
  always @* begin
    gate_next = 4'h0;
    if (bypass) begin
      gate_next[`SCC_SW1] = 1'b1;
      gate_next[`SCC_SW2] = 1'b1;
    end else if (run && (cnt_reg >= {{(HP_W-DT_W){1'b0}}, dead_time})) begin
      if (!ph_reg) begin
        gate_next[`SCC_SW1] = 1'b1;
        gate_next[`SCC_SW3] = 1'b1;
      end else begin
        gate_next[`SCC_SW2] = 1'b1;
        gate_next[`SCC_SW4] = 1'b1;
      end
    end
  end

  // registered gates, no glitches toward drivers
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gate_reg <= 4'h0;
    end else begin
      gate_reg <= gate_next;
    end
  end

endmodule // scc_phase_gen

//--- bench/scc_host_model.sv
`include "scc_defs.vh"

// host side: turns one bench command into a one-cycle write strobe
module scc_host_model (
  // command from the bench
  input  wire logic        cmd_valid,
  input  wire logic [1:0]  cmd_sel,
  input  wire logic        cmd_data,
  // write strobes with data
  output wire logic        charge_enable_bit_wr,
  output wire logic        charge_enable_bit_wdata,
  output wire logic        bypass_wr,
  output wire logic        bypass_wdata,
  output wire logic        hiz_wr,
  output wire logic        hiz_wdata,
  output wire logic        adc_en_wr,
  output wire logic        adc_en_wdata,
  // switching setup
  output wire logic [15:0] half_period,
  output wire logic [7:0]  dead_time
);
  assign charge_enable_bit_wr = cmd_valid && cmd_sel == 2'd0;
  assign bypass_wr = cmd_valid && cmd_sel == 2'd1;
  assign hiz_wr = cmd_valid && cmd_sel == 2'd2;
  assign adc_en_wr = cmd_valid && cmd_sel == 2'd3;
  // data is shared; only the strobe selects the target bit
  assign {charge_enable_bit_wdata, bypass_wdata, hiz_wdata, adc_en_wdata} = {4{cmd_data}};
  assign half_period = `SCC_HALF_PER_DEF;
  assign dead_time = `SCC_DEAD_DEF;
endmodule // scc_host_model

//--- bench/scc_charge_ctrl_chk.sv
// port checker of the charge control block
module scc_chk #(
  parameter DEB_CYC = 50
) (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       uvlo_ok,
  input wire logic       bus_present,
  input wire logic       output_present,
  input wire logic       input_one_overvoltage,
  input wire logic [11:0] fault_enable,
  input wire logic       charge_enable_bit_wr,
  input wire logic       charge_enable_bit_wdata,
  input wire logic       bypass_wr,
  input wire logic       charge_enable_bit,
  input wire logic       bypass_select_bit,
  input wire logic       high_impedance_request,
  input wire logic       converter_active_flag,
  input wire logic       adc_enable,
  input wire logic       internal_regulator,
  input wire logic [1:0] input_fet_gate_drive,
  input wire logic [3:0] gates_a,
  input wire logic [3:0] gates_b
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  en_accept_a: assert property ($rose(charge_enable_bit) |->
    $past(charge_enable_bit_wr && charge_enable_bit_wdata && bus_present && output_present))
    else $error("enable set without presence");
  flag_src_a: assert property ($rose(converter_active_flag) |->
    $past(charge_enable_bit)) else $error("flag without enable");
  mode_lock_a: assert property (converter_active_flag && bypass_wr |=>
    $stable(bypass_select_bit)) else $error("mode changed while running");
  ovp_stop_a: assert property (input_one_overvoltage && fault_enable[0] |=>
    !charge_enable_bit && !input_fet_gate_drive[0])
    else $error("overvoltage not acted on");
  hiz_off_a: assert property ($rose(high_impedance_request) |=>
    !charge_enable_bit && !internal_regulator && !adc_enable
    && input_fet_gate_drive == 2'b00) else $error("hiz left power on");
  reg_up_a: assert property ((uvlo_ok && bus_present && output_present
    && !high_impedance_request)[*3] |-> internal_regulator)
    else $error("regulator down");
  lockout_a: assert property (!uvlo_ok |=> !charge_enable_bit
    && !bypass_select_bit) else $error("bits not default");
  no_overlap_a: assert property (!bypass_select_bit |->
    !((gates_a[0] | gates_a[2]) && (gates_a[1] | gates_a[3])))
    else $error("phases overlap");
  phase_pair_a: assert property (!bypass_select_bit |->
    gates_a[0] == gates_a[2] && gates_b[1] == gates_b[3])
    else $error("switch pair split");
  bypass_on_a: assert property ((bypass_select_bit
    && converter_active_flag)[*4] |-> gates_a == 4'b0011
    && gates_b == 4'b0011) else $error("bypass gates wrong");
  interleave_a: assert property (gates_a == 4'b0101 |->
    gates_b inside {4'b1010, 4'b0000}) else $error("channels not opposite");
endmodule // scc_chk

bind scc_charge_ctrl scc_chk #(.DEB_CYC(DEB_CYC)) u_chk (.*);

//--- bench/tb_scc_charge_ctrl.sv
module tb_scc_charge_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam DEB = 50;
  // design ports
  logic sys_clk, rst_b, uvlo_ok, input_one_present, input_two_present;
  logic bus_present, output_present, bus_window_low, bus_window_high;
  logic battery_ovp_alarm, cmd_valid, cmd_data;
  logic [1:0] cmd_sel;
  logic [11:0] flt, fault_enable, fault_latch;
  wire input_one_overvoltage, input_two_overvoltage, bus_overvoltage;
  wire bus_overcurrent, bus_undercurrent, output_overvoltage, bus_short_fault;
  wire battery_overvoltage, battery_overcurrent, connector_temp_fault;
  wire battery_temp_fault, die_overtemp_fault, charge_enable_bit_wr, charge_enable_bit_wdata;
  wire bypass_wr, bypass_wdata, hiz_wr, hiz_wdata, adc_en_wr, adc_en_wdata;
  wire [15:0] half_period;
  wire [7:0] dead_time;
  logic charge_enable_bit, bypass_select_bit, high_impedance_request;
  logic converter_active_flag, adc_enable, alarm_flag, interrupt_out_n;
  logic serial_ready, internal_regulator, sensing_on;
  logic [1:0] input_fet_gate_drive;
  logic [3:0] gates_a, gates_b;
  // bench state
  int mismatches = 0, compares = 0, cycles = 0, i, na, nb, nc, nd;
  logic [31:0] seed;
  assign {die_overtemp_fault, battery_temp_fault, connector_temp_fault,
    battery_overcurrent, battery_overvoltage, bus_short_fault,
    output_overvoltage, bus_undercurrent, bus_overcurrent, bus_overvoltage,
    input_two_overvoltage, input_one_overvoltage} = flt;
  scc_host_model u_host (.*);
  scc_charge_ctrl #(.DEB_CYC(DEB)) u_dut (.*);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // hang guard, far above the planned run
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // one write: 0 enable, 1 bypass, 2 hiz, 3 adc
  task automatic wr(input logic [1:0] sel, input logic d);
    @(negedge sys_clk);
    cmd_sel = sel;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
  endtask
  task automatic close_out;
    if (mismatches == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    {cmd_valid, cmd_sel, cmd_data, rst_b, flt, battery_ovp_alarm} = '0;
    {uvlo_ok, input_one_present, input_two_present} = 3'b111;
    {bus_present, output_present, bus_window_low, bus_window_high} = 4'b1110;
    fault_enable = 12'hfff;
    seed = 32'h1543a464;
    cyc(8);
    rst_b = 1'b1;
    chk(charge_enable_bit, 0);
    wr(3, 1);
    chk(adc_enable, 1);
    for (i = 0; i < 16; i++) begin
      seed = xs(seed);
      {input_two_present, bus_present, output_present, bus_window_high} = seed;
      wr(0, 1);
      cyc(2);
      chk(charge_enable_bit, bus_present & output_present);
      chk(converter_active_flag, bus_present & output_present & !bus_window_high);
      chk(internal_regulator, bus_present & output_present);
      chk(sensing_on, bus_present & output_present);
      wr(0, 0);
      cyc(4);
    end
    {bus_present, output_present, bus_window_high} = 3'b110;
    wr(1, 0);
    wr(0, 1);
    cyc(40);
    {na, nb, nc} = '0;
    // four whole periods of 64 cycles, 30 on per half
    repeat (256) begin
      @(negedge sys_clk);
      na += gates_a == 4'b0101;
      nb += gates_a == 4'b1010;
      nc += gates_b == 4'b0101;
    end
    chk(na, 120);
    chk(nb, 120);
    chk(nc, 120);
    wr(1, 1);
    chk(bypass_select_bit, 0);
    wr(0, 0);
    cyc(6);
    wr(1, 1);
    wr(0, 1);
    cyc(8);
    chk(gates_a, 4'b0011);
    chk(gates_b, 4'b0011);
    wr(0, 0);
    cyc(6);
    uvlo_ok = 1'b0;
    cyc(2);
    chk({charge_enable_bit, bypass_select_bit}, 0);
    chk({serial_ready, sensing_on}, 0);
    uvlo_ok = 1'b1;
    for (i = 0; i < 12; i++) begin
      wr(0, 1);
      cyc(3);
      chk(serial_ready, 1);
      chk(input_fet_gate_drive, 2'b01);
      flt = 12'h001 << i;
      cyc(5);
      chk({charge_enable_bit, converter_active_flag, gates_a}, 0);
      chk(internal_regulator, 1);
      chk(fault_latch, 12'h001 << i);
      nd = i == 0 ? 1 : i == 1 ? 2 : i == 6 ? 3 : 0;
      chk(input_fet_gate_drive & nd[1:0], 0);
      flt = '0;
      cyc(2);
    end
    cyc(60);
    {na, nb} = '0;
    // alarm rises every 20 cycles; debounce keeps only two
    for (i = 0; i < 100; i++) begin
      battery_ovp_alarm = (i % 20) < 10;
      @(negedge sys_clk);
      na += alarm_flag === 1'b1;
      nb += interrupt_out_n === 1'b0;
    end
    chk(na, 2);
    chk(nb, 2);
    wr(0, 1);
    wr(2, 1);
    cyc(2);
    chk({charge_enable_bit, internal_regulator, adc_enable, input_fet_gate_drive}, 0);
    wr(0, 1);
    cyc(2);
    chk({charge_enable_bit, high_impedance_request}, 8'h01);
    wr(2, 0);
    cyc(4);
    chk(internal_regulator, 1);
    close_out();
  end
endmodule // tb_scc_charge_ctrl
